// ===== rtl/uecsd_top.sv
// Purpose: Endpoint command issue and setup request decode of a USB device.
// Assumes: AXI4-Lite master and packet engine share clk_sys.
// Notes: One write and one read at most are under way at a time.
//
// What this block does
// RULE_01: Interrupt-IN without handshake toggles PID if enabled.
// RULE_02: Zero-length reception records its endpoint number.
// RULE_03: Recorded endpoint holds until next zero-length packet.
// RULE_04: Field overwritten; per-endpoint status flags also kept.
// RULE_05: Software reads endpoint field after zero-length flag.
// RULE_06: Command acts on the command-target endpoint field.
// RULE_07: Software never targets an unimplemented endpoint.
// RULE_08: Four-bit code field selects the issued command.
// RULE_09: Codes 1,2,3: setup finish, even PID, reinit.
// RULE_10: Codes 4,5: halt, void; code 6 reserved.
// RULE_11: Codes 7,8,9: off, on, void all endpoints.
// RULE_12: Codes A,B,C: bus ready, setup acknowledge, packet end.
// RULE_13: Codes D,E: buffer flush, send empty; F,0 reserved.
// RULE_14: Second setup byte readable as request field.
// RULE_15: Setup byte bit 7 gives transfer direction.
// RULE_16: Two-bit request category from first setup byte.
// RULE_17: Five-bit request recipient from first setup byte.
// RULE_18: One command executes per command register write; here only writes with byte 0 strobed and a non-reserved code issue one.
`timescale 1ns/10ps
module uecsd_top #(
  parameter int NUM_EP = 16
) (
  // Clock and reset.
  input logic clk_sys,
  input logic rst,
  // AXI4-Lite write channels.
  input logic [uecsd_pkg::ADDR_W-1:0] awaddr,
  input logic awvalid,
  output logic awready,
  input logic [31:0] wdata,
  input logic [3:0] wstrb,
  input logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input logic bready,
  // AXI4-Lite read channels.
  input logic [uecsd_pkg::ADDR_W-1:0] araddr,
  input logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input logic rready,
  // Events from the packet engine.
  input uecsd_pkg::uecsd_zlp_s zlpIn,
  input uecsd_pkg::uecsd_setup_s setupIn,
  input uecsd_pkg::uecsd_txdone_s txDone,
  // Results towards the endpoint engine.
  output uecsd_pkg::uecsd_cmd_s cmdOut,
  output logic [uecsd_pkg::EP_MAX-1:0] dataPid,
  output uecsd_pkg::uecsd_reqinfo_s reqInfo
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (NUM_EP < 1 || NUM_EP > uecsd_pkg::EP_MAX) begin : g_bad_num_ep
    $error("NUM_EP must lie between 1 and 16.");
  end

  // ----------------------------------------------------------------
  // State and helpers
  // ----------------------------------------------------------------
  localparam logic [4:0] EP_LIMIT = 5'(NUM_EP);
  uecsd_pkg::uecsd_top_state_s s;
  uecsd_pkg::uecsd_top_state_s next_s;
  // Write commits this cycle to the command or zero-length register.
  logic wrCmd;
  logic wrZlp;
  // Sticky zero-length flags from the tracker.
  logic [uecsd_pkg::EP_MAX-1:0] zlpPending;
  uecsd_pkg::uecsd_op_e wrOp;

  // Maps a code onto its command; reserved codes give OP_NONE.
  function automatic uecsd_pkg::uecsd_op_e decodeOp(input logic [3:0] code);
    case (code)
      uecsd_pkg::CODE_SETUP_FIN: decodeOp = uecsd_pkg::OP_SETUP_FIN; // see RULE_09
      uecsd_pkg::CODE_FORCE_EVEN_PID: decodeOp = uecsd_pkg::OP_FORCE_EVEN_PID;
      uecsd_pkg::CODE_REINIT: decodeOp = uecsd_pkg::OP_REINIT;
      uecsd_pkg::CODE_HALT: decodeOp = uecsd_pkg::OP_HALT; // see RULE_10
      uecsd_pkg::CODE_VOID: decodeOp = uecsd_pkg::OP_VOID;
      uecsd_pkg::CODE_OFF: decodeOp = uecsd_pkg::OP_OFF; // see RULE_11
      uecsd_pkg::CODE_ON: decodeOp = uecsd_pkg::OP_ON;
      uecsd_pkg::CODE_VOID_ALL: decodeOp = uecsd_pkg::OP_VOID_ALL;
      uecsd_pkg::CODE_USB_READY: decodeOp = uecsd_pkg::OP_USB_READY; // see RULE_12
      uecsd_pkg::CODE_SETUP_ACK: decodeOp = uecsd_pkg::OP_SETUP_ACK;
      uecsd_pkg::CODE_PACKET_END: decodeOp = uecsd_pkg::OP_PACKET_END;
      uecsd_pkg::CODE_BUFFER_FLUSH: decodeOp = uecsd_pkg::OP_BUFFER_FLUSH; // see RULE_13
      uecsd_pkg::CODE_SEND_EMPTY: decodeOp = uecsd_pkg::OP_SEND_EMPTY;
      default: decodeOp = uecsd_pkg::OP_NONE;
    endcase
  endfunction

  assign wrOp = decodeOp(s.wdata[uecsd_pkg::CMD_CODE_LSB +: 4]);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Bus slave, event capture and command issue in one pass.
  always_comb begin
    next_s = s;
    wrCmd = 1'b0;
    wrZlp = 1'b0;
    next_s.cmd.valid = 1'b0;
    // Address and data are taken in either order and held.
    if (awvalid && s.awready) begin
      next_s.awHeld = 1'b1;
      next_s.awaddr = awaddr;
    end
    if (wvalid && s.wready) begin
      next_s.wHeld = 1'b1;
      next_s.wdata = wdata;
      next_s.wstrb = wstrb;
    end
    // Commit once both halves are held; the response follows at once.
    if (s.awHeld && s.wHeld && !s.bvalid) begin
      next_s.awHeld = 1'b0;
      next_s.wHeld = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = uecsd_pkg::RESP_OKAY;
      case (s.awaddr)
        uecsd_pkg::OFS_CMD: begin
          wrCmd = 1'b1;
        end
        uecsd_pkg::OFS_ZLP: begin
          wrZlp = 1'b1;
        end
        // Read-only registers ignore the data but answer OKAY.
        uecsd_pkg::OFS_SETUP, uecsd_pkg::OFS_PID: begin
          next_s.bresp = uecsd_pkg::RESP_OKAY;
        end
        default: begin
          next_s.bresp = uecsd_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (s.bvalid && bready) begin
      next_s.bvalid = 1'b0;
    end
    // Ready stays low while a response is owed, which bounds writes to one.
    next_s.awready = !next_s.awHeld && !next_s.bvalid;
    next_s.wready = !next_s.wHeld && !next_s.bvalid;
    // Reads answer one cycle after the address is taken.
    if (arvalid && s.arready) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = uecsd_pkg::RESP_OKAY;
      case (araddr)
        uecsd_pkg::OFS_CMD: begin
          next_s.rdata = uecsd_pkg::CMD_RESET;
          next_s.rdata[uecsd_pkg::CMD_TOGGLE_BIT] = s.intToggle;
          next_s.rdata[uecsd_pkg::CMD_ZLP_LSB +: 4] = s.zlpEp; // see RULE_02
          next_s.rdata[uecsd_pkg::CMD_EP_LSB +: 4] = s.cmdEp;
          next_s.rdata[uecsd_pkg::CMD_CODE_LSB +: 4] = s.cmdCode;
        end
        uecsd_pkg::OFS_SETUP: begin
          next_s.rdata = uecsd_pkg::SETUP_RESET;
          next_s.rdata[uecsd_pkg::SETUP_REQ_LSB +: 8] = s.setupReq; // see RULE_14
          next_s.rdata[7:0] = s.setupType;
        end
        uecsd_pkg::OFS_ZLP: begin
          next_s.rdata = {16'h0000, zlpPending}; // see RULE_04
        end
        uecsd_pkg::OFS_PID: begin
          next_s.rdata = {16'h0000, s.dataPid};
        end
        default: begin
          next_s.rdata = 32'h0000_0000;
          next_s.rresp = uecsd_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (s.rvalid && rready) begin
      next_s.rvalid = 1'b0;
    end
    next_s.arready = !next_s.rvalid;
    // Latest zero-length endpoint overwrites the field and then holds.
    if (zlpIn.valid) begin
      next_s.zlpEp = zlpIn.ep; // see RULE_02, see RULE_03, see RULE_04
    end
    // Setup bytes are kept whole; the fields are slices of them.
    if (setupIn.valid) begin
      next_s.setupType = setupIn.byte0; // see RULE_15
      next_s.setupReq = setupIn.byte1; // see RULE_14
    end
    // A handshake advances the PID unless a PID reset command overrides it; a missing one only on an interrupt IN, and only if enabled.
    if (txDone.valid && ({1'b0, txDone.ep} < EP_LIMIT)) begin
      if (txDone.acked || (txDone.isInterrupt && s.intToggle)) begin // see RULE_01
        next_s.dataPid[txDone.ep] = !s.dataPid[txDone.ep];
      end
    end
    // A command write with byte 0 strobed and a non-reserved code issues one command with its own fields.
    if (wrCmd) begin
      if (s.wstrb[1]) begin
        next_s.intToggle = s.wdata[uecsd_pkg::CMD_TOGGLE_BIT]; // see RULE_01
      end
      if (s.wstrb[0]) begin
        next_s.cmdEp = s.wdata[uecsd_pkg::CMD_EP_LSB +: 4]; // see RULE_06
        next_s.cmdCode = s.wdata[uecsd_pkg::CMD_CODE_LSB +: 4]; // see RULE_08
        next_s.cmd.ep = s.wdata[uecsd_pkg::CMD_EP_LSB +: 4]; // see RULE_06
        next_s.cmd.op = wrOp;
        // Reserved codes are stored but never reach the endpoint engine.
        next_s.cmd.valid = (wrOp != uecsd_pkg::OP_NONE); // see RULE_18
        // A software reset of the PID overrides a toggle in the same cycle.
        if ((wrOp == uecsd_pkg::OP_FORCE_EVEN_PID || wrOp == uecsd_pkg::OP_REINIT)
            && ({1'b0, next_s.cmdEp} < EP_LIMIT)) begin // see RULE_09
          next_s.dataPid[next_s.cmdEp] = 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Everything clears on reset; bus readies rise one edge after release.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Per-endpoint sticky zero-length flags, cleared by writing ones.
  uecsd_zlp_track #(
    .NUM_EP(NUM_EP)
  ) u_zlp_track (
    .clk_sys(clk_sys),
    .rst(rst),
    .zlpIn(zlpIn),
    .clrValid(wrZlp && s.wstrb[0] && s.wstrb[1]),
    .clrMask(s.wdata[15:0]),
    .pending(zlpPending)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign awready = s.awready;
  assign wready = s.wready;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = s.arready;
  assign rvalid = s.rvalid;
  assign rresp = s.rresp;
  assign rdata = s.rdata;
  assign cmdOut = s.cmd;
  assign dataPid = s.dataPid;
  assign reqInfo.dir = s.setupType[uecsd_pkg::SETUP_DIR_BIT]; // see RULE_15
  assign reqInfo.reqType = s.setupType[uecsd_pkg::SETUP_TYPE_LSB +: 2]; // see RULE_16
  assign reqInfo.recipient = s.setupType[uecsd_pkg::SETUP_RCPT_LSB +: 5]; // see RULE_17

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  a_toggle_on_miss: assert property ( // see RULE_01
    txDone.valid && !txDone.acked && txDone.isInterrupt && s.intToggle && !wrCmd
    && ({1'b0, txDone.ep} < EP_LIMIT)
    |=> dataPid[$past(txDone.ep)] != $past(dataPid[txDone.ep]))
    else $error("Interrupt PID did not advance without handshake.");

  a_hold_on_miss: assert property ( // see RULE_01
    txDone.valid && !txDone.acked && !s.intToggle && !wrCmd
    |=> $stable(dataPid))
    else $error("PID advanced without handshake while disabled.");

  a_zlp_record: assert property ( // see RULE_02
    zlpIn.valid |=> s.zlpEp == $past(zlpIn.ep))
    else $error("Zero-length endpoint not recorded.");

  a_zlp_hold: assert property ( // see RULE_03
    !zlpIn.valid |=> $stable(s.zlpEp))
    else $error("Zero-length endpoint changed without a packet.");

  a_zlp_flag_set: assert property ( // see RULE_04
    zlpIn.valid && ({1'b0, zlpIn.ep} < EP_LIMIT) |=> zlpPending[$past(zlpIn.ep)])
    else $error("Per-endpoint zero-length flag not set.");

  a_cmd_fields: assert property ( // see RULE_06
    wrCmd && s.wstrb[0] && wrOp != uecsd_pkg::OP_NONE
    |=> cmdOut.valid && cmdOut.ep == $past(s.wdata[7:4]))
    else $error("Command issued to the wrong endpoint.");

  a_cmd_even_pid: assert property ( // see RULE_09
    wrCmd && s.wstrb[0] && s.wdata[3:0] == 4'h2
    |=> cmdOut.op == uecsd_pkg::OP_FORCE_EVEN_PID ##0 !dataPid[cmdOut.ep])
    else $error("Even PID command misdecoded.");

  a_cmd_halt: assert property ( // see RULE_10
    wrCmd && s.wstrb[0] && s.wdata[3:0] == 4'h4 |=> cmdOut.op == uecsd_pkg::OP_HALT)
    else $error("Halt command misdecoded.");

  a_cmd_reserved: assert property ( // see RULE_13
    wrCmd && s.wstrb[0] && (s.wdata[3:0] == 4'h6 || s.wdata[3:0] == 4'hF
    || s.wdata[3:0] == 4'h0) |=> !cmdOut.valid)
    else $error("Reserved code issued a command.");

  a_cmd_single: assert property ( // see RULE_18
    cmdOut.valid |=> !cmdOut.valid [*2])
    else $error("One write issued more than one command.");

  a_setup_fields: assert property ( // see RULE_16
    setupIn.valid |=> reqInfo.reqType == $past(setupIn.byte0[6:5])
    && reqInfo.dir == $past(setupIn.byte0[7])
    && reqInfo.recipient == $past(setupIn.byte0[4:0]))
    else $error("Setup request type fields wrong.");

  a_write_answer: assert property (
    s.awHeld && s.wHeld && !s.bvalid |=> bvalid && !awready && !wready)
    else $error("Write response not given one cycle after commit.");

  c_interrupt_miss: cover property (
    txDone.valid && txDone.isInterrupt && !txDone.acked && s.intToggle);
  c_zlp_then_cmd: cover property (zlpIn.valid ##[1:20] cmdOut.valid);
  c_setup_read: cover property (setupIn.valid ##[1:20] (rvalid && rready));

endmodule // uecsd_top

// ===== rtl/uecsd_pkg.sv
// Purpose: Shared constants and types of the endpoint command and setup decode block.
// Assumes: One system clock; the packet engine runs on that same clock.
// Notes: Register offsets are byte addresses on a 32-bit register bus.
package uecsd_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  // Largest endpoint count that a 4-bit endpoint number can address.
  localparam int EP_MAX = 16;
  // Register address width seen by the block.
  localparam int ADDR_W = 8;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_SETUP = 8'h04;
  localparam logic [7:0] OFS_ZLP = 8'h08;
  localparam logic [7:0] OFS_PID = 8'h0C;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CMD_CODE_LSB = 0;
  localparam int CMD_EP_LSB = 4;
  localparam int CMD_ZLP_LSB = 8;
  localparam int CMD_TOGGLE_BIT = 15;
  localparam int SETUP_REQ_LSB = 8;
  localparam int SETUP_DIR_BIT = 7;
  localparam int SETUP_TYPE_LSB = 5;
  localparam int SETUP_RCPT_LSB = 0;
  localparam logic [31:0] CMD_RESET = 32'h0000_0000;
  localparam logic [31:0] SETUP_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Command codes and bus responses
  // ----------------------------------------------------------------
  localparam logic [3:0] CODE_SETUP_FIN = 4'h1;
  localparam logic [3:0] CODE_FORCE_EVEN_PID = 4'h2;
  localparam logic [3:0] CODE_REINIT = 4'h3;
  localparam logic [3:0] CODE_HALT = 4'h4;
  localparam logic [3:0] CODE_VOID = 4'h5;
  localparam logic [3:0] CODE_OFF = 4'h7;
  localparam logic [3:0] CODE_ON = 4'h8;
  localparam logic [3:0] CODE_VOID_ALL = 4'h9;
  localparam logic [3:0] CODE_USB_READY = 4'hA;
  localparam logic [3:0] CODE_SETUP_ACK = 4'hB;
  localparam logic [3:0] CODE_PACKET_END = 4'hC;
  localparam logic [3:0] CODE_BUFFER_FLUSH = 4'hD;
  localparam logic [3:0] CODE_SEND_EMPTY = 4'hE;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Decoded command; OP_NONE stands for the reserved codes.
  typedef enum logic [3:0] {
    OP_NONE, OP_SETUP_FIN, OP_FORCE_EVEN_PID, OP_REINIT, OP_HALT, OP_VOID,
    OP_OFF, OP_ON, OP_VOID_ALL, OP_USB_READY, OP_SETUP_ACK, OP_PACKET_END,
    OP_BUFFER_FLUSH, OP_SEND_EMPTY
  } uecsd_op_e;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  // Command strobe towards the endpoint engine.
  typedef struct packed {
    logic valid;
    logic [3:0] ep;
    uecsd_op_e op;
  } uecsd_cmd_s;

  // Zero-length packet received on an OUT endpoint.
  typedef struct packed {
    logic valid;
    logic [3:0] ep;
  } uecsd_zlp_s;

  // First two bytes of a received setup packet.
  typedef struct packed {
    logic valid;
    logic [7:0] byte0;
    logic [7:0] byte1;
  } uecsd_setup_s;

  // End of an IN transaction.
  typedef struct packed {
    logic valid;
    logic [3:0] ep;
    logic acked;
    logic isInterrupt;
  } uecsd_txdone_s;

  // Decoded fields of the request type byte.
  typedef struct packed {
    logic dir;
    logic [1:0] reqType;
    logic [4:0] recipient;
  } uecsd_reqinfo_s;

  // Whole state of the top module.
  typedef struct packed {
    logic awready;
    logic wready;
    logic arready;
    logic bvalid;
    logic rvalid;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic awHeld;
    logic wHeld;
    logic [ADDR_W-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic intToggle;
    logic [3:0] cmdEp;
    logic [3:0] cmdCode;
    uecsd_cmd_s cmd;
    logic [3:0] zlpEp;
    logic [7:0] setupType;
    logic [7:0] setupReq;
    logic [EP_MAX-1:0] dataPid;
  } uecsd_top_state_s;

  // Whole state of the zero-length status tracker.
  typedef struct packed {
    logic [EP_MAX-1:0] pending;
  } uecsd_zlp_state_s;

endpackage

// ===== rtl/uecsd_zlp_track.sv
// Purpose: Per-endpoint sticky record of received zero-length packets.
// Assumes: Set and clear arrive on the system clock.
// Notes: A set in the cycle of its clear wins, so no event is lost.
`timescale 1ns/10ps
module uecsd_zlp_track #(
  parameter int NUM_EP = 16
) (
  // Clock and reset.
  input logic clk_sys,
  input logic rst,
  // Zero-length reception from the packet engine.
  input uecsd_pkg::uecsd_zlp_s zlpIn,
  // Write-one-to-clear from the register bus.
  input logic clrValid,
  input logic [uecsd_pkg::EP_MAX-1:0] clrMask,
  // Sticky flags, one per endpoint.
  output logic [uecsd_pkg::EP_MAX-1:0] pending
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  uecsd_pkg::uecsd_zlp_state_s s;
  uecsd_pkg::uecsd_zlp_state_s next_s;
  logic [uecsd_pkg::EP_MAX-1:0] setBit;
  logic [uecsd_pkg::EP_MAX-1:0] clrBit;

  // Endpoints from NUM_EP upward never set, so their flags stay zero.
  for (genvar i = 0; i < uecsd_pkg::EP_MAX; i++) begin : g_ep
    if (i < NUM_EP) begin : g_live
      assign setBit[i] = zlpIn.valid && (zlpIn.ep == 4'(i));
    end else begin : g_dead
      assign setBit[i] = 1'b0;
    end
    assign clrBit[i] = clrValid && clrMask[i];
  end

  // ----------------------------------------------------------------
  // Update
  // ----------------------------------------------------------------
  // Set has priority over clear.
  always_comb begin
    next_s.pending = setBit | (s.pending & ~clrBit); // see RULE_04
  end

  // Synchronous reset clears every flag.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign pending = s.pending;

endmodule // uecsd_zlp_track

// ===== testbench/uecsd_usb_host.sv
// Purpose: Packet engine stand-in that raises zero-length, setup and IN-done events.
// Assumes: Events are one-cycle pulses on clk_sys.
// Notes: Endpoint and setup payloads turn to inverted values once a pulse ends, so that stale data shows.
`timescale 1ns/10ps
module uecsd_usb_host (
  // Clock.
  input wire logic clk_sys,
  // Event pulses towards the block.
  output uecsd_pkg::uecsd_zlp_s zlpIn,
  output uecsd_pkg::uecsd_setup_s setupIn,
  output uecsd_pkg::uecsd_txdone_s txDone
);
  // All event lines start idle.
  initial begin
    zlpIn = '0;
    setupIn = '0;
    txDone = '0;
  end

  // A zero-length OUT packet arrives on one endpoint.
  task automatic sendZlp(input logic [3:0] ep);
    @(posedge clk_sys);
    zlpIn <= {1'h1, ep};
    @(posedge clk_sys);
    zlpIn <= {1'h0, ~ep};
  endtask

  // A setup packet arrives; only its first two bytes matter here.
  task automatic sendSetup(input logic [7:0] b0, input logic [7:0] b1);
    @(posedge clk_sys);
    setupIn <= {1'h1, b0, b1};
    @(posedge clk_sys);
    setupIn <= {1'h0, ~b0, ~b1};
  endtask

  // An IN transaction ends, with or without a handshake from the host.
  task automatic sendTx(input logic [3:0] ep, input logic ack, input logic intr);
    @(posedge clk_sys);
    txDone <= {1'h1, ep, ack, intr};
    @(posedge clk_sys);
    txDone <= {1'h0, ~ep, 1'h0, 1'h0};
  endtask
endmodule // uecsd_usb_host

// ===== testbench/tb_top.sv
// Purpose: Self-checking bench of the command and setup decode block.
// Assumes: Register bus is driven as an AXI4-Lite master on clk_sys.
// Notes: Expected values are worked out here from the field layout.
`timescale 1ns/10ps
module tb_top;
  logic clk_sys = 1'h0;
  logic rst = 1'h1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'h0, ep;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  uecsd_pkg::uecsd_zlp_s zlpIn;
  uecsd_pkg::uecsd_setup_s setupIn;
  uecsd_pkg::uecsd_txdone_s txDone;
  uecsd_pkg::uecsd_cmd_s cmdOut, lastCmd;
  logic [15:0] dataPid;
  uecsd_pkg::uecsd_reqinfo_s reqInfo;
  logic [7:0] b0Tab [4] = '{8'h80, 8'h21, 8'hC2, 8'h03};
  int mismatches = 0, checks_done = 0, pulses = 0, p0;
  logic rsv;

  always #5 clk_sys = ~clk_sys;

  uecsd_top #(.NUM_EP(16)) dut (.clk_sys, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .zlpIn, .setupIn, .txDone, .cmdOut, .dataPid, .reqInfo);
  uecsd_usb_host host (.clk_sys, .zlpIn, .setupIn, .txDone);

  // Count command pulses and keep the last one for comparison.
  always @(posedge clk_sys) begin
    if (cmdOut.valid === 1'h1) begin
      pulses <= pulses + 1;
      lastCmd <= cmdOut;
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Write: address and data offered together, each released when taken.
  task automatic axWrite(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                         input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge clk_sys);
      n++;
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
    end while (bvalid !== 1'h1 && n < 50);
    bready <= 1'h0;
    // A response that never came counts as a mismatch here.
    chk("bvalid", 32'(bvalid), 32'h1);
    chk("bresp", 32'(bresp), 32'(er));
  endtask

  // Read one word and compare data and response.
  task automatic rdChk(input string nm, input logic [7:0] a, input logic [31:0] e,
                       input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge clk_sys);
      n++;
      if (arready === 1'h1) arvalid <= 1'h0;
    end while (rvalid !== 1'h1 && n < 50);
    rready <= 1'h0;
    // A read that never answered counts as a mismatch here.
    chk("rvalid", 32'(rvalid), 32'h1);
    chk(nm, rdata, e);
    chk("rresp", 32'(rresp), 32'(er));
  endtask

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Watchdog: the whole run needs well under two thousand cycles.
  initial begin
    repeat (8000) @(posedge clk_sys);
    mismatches++;
    results();
  end

  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'h0;
    rdChk("cmd reset", 8'h00, 32'h0, 2'h0);
    rdChk("setup reset", 8'h04, 32'h0, 2'h0);
    rdChk("unmapped", 8'h10, 32'h0, 2'h2);
    $display("Test reset and map done");
    // Every code once; reserved codes are stored but raise no pulse.
    for (int c = 0; c < 16; c++) begin
      p0 = pulses;
      ep = 4'hF - c[3:0];
      axWrite(8'h00, {24'h0, ep, c[3:0]}, 4'h1, 2'h0);
      repeat (2) @(posedge clk_sys);
      rsv = (c == 0 || c == 6 || c == 15);
      chk("pulses", 32'(pulses - p0), rsv ? 32'h0 : 32'h1);
      if (!rsv) begin
        chk("cmd ep", 32'(lastCmd.ep), 32'(ep));
        chk("cmd op", 32'(lastCmd.op), 32'(c < 6 ? c : c - 1));
      end
      rdChk("cmd back", 8'h00, {24'h0, ep, c[3:0]}, 2'h0);
    end
    $display("Test command codes done");
    host.sendZlp(4'h5);
    host.sendZlp(4'h9);
    rdChk("zlp flags", 8'h08, 32'h0000_0220, 2'h0);
    rdChk("zlp ep", 8'h00, 32'h0000_090F, 2'h0);
    axWrite(8'h00, 32'h0000_0F31, 4'h3, 2'h0);
    rdChk("zlp hold", 8'h00, 32'h0000_0931, 2'h0);
    axWrite(8'h08, 32'h0000_0020, 4'h3, 2'h0);
    rdChk("zlp clear", 8'h08, 32'h0000_0200, 2'h0);
    $display("Test zero-length done");
    for (int i = 0; i < 4; i++) begin
      host.sendSetup(b0Tab[i], 8'h06 + 8'(i));
      @(posedge clk_sys);
      chk("dir", 32'(reqInfo.dir), 32'(b0Tab[i][7]));
      chk("type", 32'(reqInfo.reqType), 32'(b0Tab[i][6:5]));
      chk("rcpt", 32'(reqInfo.recipient), 32'(b0Tab[i][4:0]));
      rdChk("setup", 8'h04, {16'h0, 8'h06 + 8'(i), b0Tab[i]}, 2'h0);
    end
    axWrite(8'h04, 32'hFFFF_FFFF, 4'hF, 2'h0);
    rdChk("setup ro", 8'h04, 32'h0000_0903, 2'h0);
    $display("Test setup decode done");
    host.sendTx(4'h2, 1'h1, 1'h0);
    @(posedge clk_sys);
    chk("pid ack", 32'(dataPid), 32'h4);
    host.sendTx(4'h2, 1'h0, 1'h1);
    @(posedge clk_sys);
    chk("pid int off", 32'(dataPid), 32'h4);
    axWrite(8'h00, 32'h0000_8000, 4'h2, 2'h0);
    host.sendTx(4'h2, 1'h0, 1'h1);
    @(posedge clk_sys);
    chk("pid int on", 32'(dataPid), 32'h0);
    host.sendTx(4'h2, 1'h1, 1'h0);
    axWrite(8'h00, 32'h0000_8022, 4'h3, 2'h0);
    @(posedge clk_sys);
    chk("pid forced", 32'(dataPid), 32'h0);
    rdChk("toggle bit", 8'h00, 32'h0000_8922, 2'h0);
    $display("Test data PID done");
    results();
  end
endmodule // tb_top
